// ==== typec_cc_register_bank.sv ====
// register bank of a type-c configuration-channel controller behind an i2c target
`timescale 1ns/100ps
`include "typec_cc_map.svh"

module typec_cc_register_bank
  import typec_cc_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  input  wire attach_report_t attach_report,
  output logic                interrupt_request_out_n,
  output logic                sink_attached_out,
  output logic                vbus_source_out,
  output port_cfg_t           port_cfg_out,
  output cc_pull_t            cc_pull_out
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // control byte to port configuration
  function automatic port_cfg_t decode_control(input logic [7:0] ctl);
    port_cfg_t  cfg;
    logic [7:0] mode;
    cfg           = '0;
    mode          = ctl & `CTL_MODE_CLEAR;
    cfg.irq_mask  = ctl[`CTL_MASK_BIT];
    cfg.role      = ROLE_SINK;
    cfg.adv       = ADV_NONE;
    unique case (ctl[`CTL_CUR_MSB:`CTL_CUR_LSB])
      2'h0:    cfg.adv = ADV_DEFAULT;
      2'h1:    cfg.adv = ADV_1A5;
      default: cfg.adv = ADV_3A;
    endcase
    case (mode)
      `CTL_SRC_DEF, `CTL_SRC_1A5, `CTL_SRC_3A: begin
        cfg.role = ROLE_SOURCE;
      end
      `CTL_DRP_DEF, `CTL_DRP_1A5, `CTL_DRP_3A: begin
        cfg.role = ROLE_DRP;
      end
      `CTL_TSRC_DEF, `CTL_TSRC_1A5, `CTL_TSRC_3A: begin
        cfg.role    = ROLE_DRP;
        cfg.try_src = 1'b1;
      end
      `CTL_TSNK_DEF, `CTL_TSNK_1A5, `CTL_TSNK_3A: begin
        cfg.role    = ROLE_DRP;
        cfg.try_snk = 1'b1;
      end
      `CTL_SINK_ACC: begin
        cfg.accessory = 1'b1;
        cfg.adv       = ADV_NONE;
      end
      default: begin
        cfg.adv = ADV_NONE;
      end
    endcase
    return cfg;
  endfunction : decode_control

  // status code that means a sink partner is attached and vbus is sourced
  function automatic logic is_source_attached(input logic [7:0] code);
    return (code == `ST_SRC_CC1) || (code == `ST_SRC_CC1_ACT) ||
           (code == `ST_SRC_CC2) || (code == `ST_SRC_CC2_ACT);
  endfunction : is_source_attached

  // unattached line behaviour of a configuration
  function automatic cc_pull_t idle_pull(input port_cfg_t cfg);
    cc_pull_t p;
    p = PULL_GND;
    if (cfg.role == ROLE_SOURCE) begin
      p = PULL_VDD;
    end else if (cfg.role == ROLE_DRP || cfg.accessory) begin
      p = PULL_TOGGLE;
    end
    return p;
  endfunction : idle_pull

  ////////////////////////////////////////////////////////////////////////////
  // registers

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_START,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_WR_DATA,
    I2C_WR_ACK,
    I2C_RD_DATA,
    I2C_RD_ACK
  } i2c_state_t;

  i2c_state_t  state_q,   state_d;
  logic        scl_q,     sda_q;
  logic [2:0]  bit_q,     bit_d;
  logic [7:0]  shift_q,   shift_d;
  logic [2:0]  ptr_q,     ptr_d;
  logic        rd_q,      rd_d;
  logic        oe_q,      oe_d;
  logic [7:0]  control_q, control_d;
  logic [7:0]  events_q,  events_d;
  logic [7:0]  status_q,  status_d;
  logic        irq_n_q;
  logic        sink_att_q;
  logic        vbus_q;
  port_cfg_t   cfg_q;
  cc_pull_t    pull_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions and register decode

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [7:0]  rx_byte;
  logic [7:0]  read_byte;
  logic        addr_hit;
  logic        ptr_inc_ok;
  logic        read_events;
  logic        write_control;
  logic        was_attached;
  logic        now_attached;
  logic        set_attach;
  logic        set_detach;
  logic [7:0]  event_set;
  logic [7:0]  event_clr;
  port_cfg_t   cfg_now;

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
  assign rx_byte    = {shift_q[6:0], sda_in};
  assign addr_hit   = (rx_byte[7:1] == `I2C_DEV_ADDR);
  assign ptr_inc_ok = (ptr_q <= `REG_LAST);

  // sequential register image from the first register onward
  assign read_byte = (ptr_q == `REG_FIRST)   ? `ID_BYTE_VALUE :
                     (ptr_q == `REG_CONTROL) ? control_q :
                     (ptr_q == `REG_EVENTS)  ? events_q :
                     (ptr_q == `REG_STATUS)  ? status_q :
                                               `READ_FILL;

  // byte loaded for transmission from the events register clears it
  assign read_events = (state_q == I2C_ADDR_ACK && rd_q && scl_fall &&
                        ptr_q == `REG_EVENTS) ||
                       (state_q == I2C_RD_ACK && scl_fall && ~sda_q &&
                        ptr_q == `REG_EVENTS);

  assign write_control = (state_q == I2C_WR_DATA) && scl_rise &&
                         (bit_q == `BIT_LAST) && (ptr_q == `REG_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // attach tracking and events

  assign was_attached = (status_q != `STATUS_UNATTACHED);
  assign now_attached = (attach_report.code != `STATUS_UNATTACHED);
  assign set_attach   = attach_report.valid & ~was_attached & now_attached;
  assign set_detach   = attach_report.valid & was_attached & ~now_attached;

  always_comb begin
    event_set = `EVENTS_NONE;
    event_set[`EVT_ATTACH_BIT] = set_attach;
    event_set[`EVT_DETACH_BIT] = set_detach;
  end

  assign event_clr = read_events ? events_q : `EVENTS_NONE;
  assign events_d  = (events_q & ~event_clr) | event_set;

  // status follows only reported changes
  assign status_d  = attach_report.valid ? attach_report.code : status_q;

  assign control_d = write_control ? rx_byte : control_q;
  assign cfg_now   = decode_control(control_q);

  ////////////////////////////////////////////////////////////////////////////
  // i2c target sequencer

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    rd_d    = rd_q;
    oe_d    = oe_q;
    if (stop_cond) begin
      state_d = I2C_IDLE;
      oe_d    = 1'b0;
    end else if (start_cond) begin
      state_d = I2C_START;
      bit_d   = `BIT_FIRST;
      ptr_d   = `REG_FIRST;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        I2C_IDLE: begin
          oe_d = 1'b0;
        end
        // clock fall that closes the start, no bit yet
        I2C_START: begin
          if (scl_fall) begin
            state_d = I2C_ADDR;
          end
        end
        I2C_ADDR: begin
          if (scl_rise) begin
            shift_d = rx_byte;
            bit_d   = bit_q + 3'h1;
            rd_d    = sda_in;
          end else if (scl_fall && bit_q == `BIT_FIRST) begin
            if (shift_q[7:1] == `I2C_DEV_ADDR) begin
              state_d = I2C_ADDR_ACK;
              oe_d    = 1'b1;
            end else begin
              state_d = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (scl_fall) begin
            bit_d = `BIT_FIRST;
            if (rd_q) begin
              state_d = I2C_RD_DATA;
              shift_d = read_byte;
              oe_d    = ~read_byte[7];
              ptr_d   = ptr_inc_ok ? ptr_q + 3'h1 : ptr_q;
            end else begin
              state_d = I2C_WR_DATA;
              oe_d    = 1'b0;
            end
          end
        end
        I2C_WR_DATA: begin
          if (scl_rise) begin
            shift_d = rx_byte;
            bit_d   = bit_q + 3'h1;
          end else if (scl_fall && bit_q == `BIT_FIRST) begin
            state_d = I2C_WR_ACK;
            oe_d    = 1'b1;
            ptr_d   = ptr_inc_ok ? ptr_q + 3'h1 : ptr_q;
          end
        end
        I2C_WR_ACK: begin
          if (scl_fall) begin
            state_d = I2C_WR_DATA;
            oe_d    = 1'b0;
          end
        end
        I2C_RD_DATA: begin
          if (scl_fall) begin
            if (bit_q == `BIT_LAST) begin
              state_d = I2C_RD_ACK;
              oe_d    = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = ~shift_q[6];
              bit_d   = bit_q + 3'h1;
            end
          end
        end
        I2C_RD_ACK: begin
          if (scl_fall) begin
            bit_d = `BIT_FIRST;
            if (~sda_q) begin
              state_d = I2C_RD_DATA;
              shift_d = read_byte;
              oe_d    = ~read_byte[7];
              ptr_d   = ptr_inc_ok ? ptr_q + 3'h1 : ptr_q;
            end else begin
              state_d = I2C_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flops

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= I2C_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_q   <= `BIT_FIRST;
      shift_q <= `READ_FILL;
      ptr_q   <= `REG_FIRST;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      rd_q    <= rd_d;
      oe_q    <= oe_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_q <= `CONTROL_RESET;
      events_q  <= `EVENTS_NONE;
      status_q  <= `STATUS_UNATTACHED;
    end else begin
      control_q <= control_d;
      events_q  <= events_d;
      status_q  <= status_d;
    end
  end

  // port outputs, one flop stage behind the registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_n_q    <= 1'b1;
      sink_att_q <= 1'b1;
      vbus_q     <= 1'b0;
      cfg_q      <= '0;
      pull_q     <= PULL_GND;
    end else begin
      irq_n_q    <= ~((events_q != `EVENTS_NONE) & ~cfg_now.irq_mask);
      sink_att_q <= ~is_source_attached(status_q);
      vbus_q     <= is_source_attached(status_q);
      cfg_q      <= cfg_now;
      pull_q     <= was_attached ? PULL_ATTACHED : idle_pull(cfg_now);
    end
  end

  assign sda_out                 = 1'b0;
  assign sda_oe                  = oe_q;
  assign interrupt_request_out_n = irq_n_q;
  assign sink_attached_out       = sink_att_q;
  assign vbus_source_out         = vbus_q;
  assign port_cfg_out            = cfg_q;
  assign cc_pull_out             = pull_q;

endmodule : typec_cc_register_bank

// ==== typec_cc_map.svh ====
// register map, codes and field positions of the configuration-channel register bank
`ifndef TYPEC_CC_MAP_SVH
`define TYPEC_CC_MAP_SVH

// bus address, arbitrary value standing in for the strapped address
`define I2C_DEV_ADDR      7'h1d
// identity byte at the first register, arbitrary value
`define ID_BYTE_VALUE     8'h5a

// register pointer values
`define REG_FIRST         3'h1
`define REG_CONTROL       3'h2
`define REG_EVENTS        3'h3
`define REG_STATUS        3'h4
`define REG_LAST          3'h4

// reset and idle values
`define CONTROL_RESET     8'h00
`define EVENTS_NONE       8'h00
`define STATUS_UNATTACHED 8'h00
`define READ_FILL         8'h00

// control register fields
`define CTL_MASK_BIT      0
`define CTL_CUR_LSB       3
`define CTL_CUR_MSB       4
`define CTL_MODE_CLEAR    8'hfe
`define CTL_SINK          8'h00
`define CTL_SINK_ACC      8'h20
`define CTL_SRC_DEF       8'h02
`define CTL_SRC_1A5       8'h0a
`define CTL_SRC_3A        8'h12
`define CTL_DRP_DEF       8'h04
`define CTL_DRP_1A5       8'h0c
`define CTL_DRP_3A        8'h14
`define CTL_TSRC_DEF      8'h06
`define CTL_TSRC_1A5      8'h0e
`define CTL_TSRC_3A       8'h16
`define CTL_TSNK_DEF      8'h46
`define CTL_TSNK_1A5      8'h4e
`define CTL_TSNK_3A       8'h56

// event register flag positions
`define EVT_ATTACH_BIT    0
`define EVT_DETACH_BIT    1

// status codes
`define ST_SRC_CC1        8'h05
`define ST_SRC_CC1_ACT    8'h15
`define ST_SRC_CC2        8'h06
`define ST_SRC_CC2_ACT    8'h16
`define ST_AUDIO          8'h0f
`define ST_AUDIO_CT       8'h8f
`define ST_DEBUG          8'h13
`define ST_DEBUG_VBUS     8'h93
`define ST_SNK_DEF_CC1    8'ha9
`define ST_SNK_DEF_CC2    8'haa
`define ST_SNK_1A5_CC1    8'hc9
`define ST_SNK_1A5_CC2    8'hca
`define ST_SNK_3A_CC1     8'he9
`define ST_SNK_3A_CC2     8'hea

// bit counter
`define BIT_LAST          3'h7
`define BIT_FIRST         3'h0

`endif

// ==== typec_cc_pkg.sv ====
// types shared by the configuration-channel register bank
package typec_cc_pkg;

  typedef enum logic [1:0] {
    PULL_GND,
    PULL_VDD,
    PULL_TOGGLE,
    PULL_ATTACHED
  } cc_pull_t;

  typedef enum logic [1:0] {
    ADV_DEFAULT,
    ADV_1A5,
    ADV_3A,
    ADV_NONE
  } adv_current_t;

  typedef enum logic [1:0] {
    ROLE_SINK,
    ROLE_SOURCE,
    ROLE_DRP
  } port_role_t;

  typedef struct packed {
    port_role_t   role;
    adv_current_t adv;
    logic         try_src;
    logic         try_snk;
    logic         accessory;
    logic         irq_mask;
  } port_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } attach_report_t;

endpackage : typec_cc_pkg

// ==== typec_cc_props.sv ====
// port checks of the configuration-channel register bank
`timescale 1ns/100ps
module typec_cc_props
  import typec_cc_pkg::*;
(
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire logic           scl_in,
  input wire logic           sda_in,
  input wire logic           sda_out,
  input wire logic           sda_oe,
  input wire attach_report_t attach_report,
  input wire logic           interrupt_request_out_n,
  input wire logic           sink_attached_out,
  input wire logic           vbus_source_out,
  input wire port_cfg_t      port_cfg_out,
  input wire cc_pull_t       cc_pull_out
);
  logic [7:0] seen_q;
  logic       vld;
  logic [7:0] code;
  logic       src_code;
  logic       edge_evt;
  ////////////////////////////////////////////////////////////
  assign vld      = attach_report.valid;
  assign code     = attach_report.code;
  assign src_code = code inside {8'h05, 8'h15, 8'h06, 8'h16};
  assign edge_evt = (code != 8'h00) != (seen_q != 8'h00);
  always_ff @(posedge mclk) begin
    if (!rst_n)
      seen_q <= 8'h00;
    else if (vld)
      seen_q <= code;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  reset_out_a: assert property (disable iff (1'b0) !rst_n |=> interrupt_request_out_n
    && sink_attached_out && !vbus_source_out && !sda_oe && cc_pull_out == PULL_GND)
    else $error("outputs off their reset values");
  vbus_pair_a: assert property (sink_attached_out != vbus_source_out)
    else $error("sink-attached and vbus outputs agree");
  src_attach_a: assert property (vld && src_code ##1 !vld |=>
    !sink_attached_out && vbus_source_out) else $error("sink partner not reported");
  other_attach_a: assert property (vld && !src_code ##1 !vld |=>
    sink_attached_out && !vbus_source_out) else $error("sink-attached dropped");
  irq_event_a: assert property (vld && edge_evt && !port_cfg_out.irq_mask ##1 !vld |=>
    !interrupt_request_out_n) else $error("interrupt request not raised");
  irq_mask_a: assert property (port_cfg_out.irq_mask && $past(port_cfg_out.irq_mask) |->
    interrupt_request_out_n) else $error("masked interrupt request raised");
  cc_attached_a: assert property (vld && code != 8'h00 ##1 !vld |=>
    cc_pull_out == PULL_ATTACHED) else $error("cc pull not attached");
  cc_idle_a: assert property (vld && code == 8'h00 ##1 !vld |=>
    cc_pull_out != PULL_ATTACHED) else $error("cc pull still attached");
  oe_steady_a: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |->
    $stable(sda_oe)) else $error("data moved while clock high");
  od_low_a: assert property (!sda_out)
    else $error("data line driven high");
endmodule : typec_cc_props

// ==== cc_i2c_host.sv ====
// i2c controller model standing for the host processor
`timescale 1ns/100ps
module cc_i2c_host (
  input  wire logic mclk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  logic host_low = 1'b0;
  // pulled-up open-drain data wire
  assign sda = !(host_low || (sda_oe && !sda_out));
  initial scl = 1'b1;
  ////////////////////////////////////////////////////////////
  task automatic tick();
    repeat (5) @(negedge mclk);
  endtask : tick
  task automatic start();
    host_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask : start
  task automatic stop();
    host_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    host_low = 1'b0;
    tick();
  endtask : stop
  // data held across clock high, sampled at the end of clock high
  task automatic bit_io(input logic b, output logic r);
    host_low = !b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask : bit_io
  // msb first, ninth bit is the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : cc_i2c_host

// ==== test_typec_cc_register_bank.sv ====
// self-checking bench of the configuration-channel register bank
`timescale 1ns/100ps
`include "typec_cc_map.svh"
module test_typec_cc_register_bank
  import typec_cc_pkg::*;
;
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  logic           scl_in;
  logic           sda_in;
  logic           sda_out;
  logic           sda_oe;
  attach_report_t attach_report = '0;
  logic           interrupt_request_out_n;
  logic           sink_attached_out;
  logic           vbus_source_out;
  port_cfg_t      port_cfg_out;
  cc_pull_t       cc_pull_out;
  int             n_fail = 0;
  int             total_checks = 0;
  logic [7:0]     rd [5];
  logic           ack;
  logic [7:0]     ctl_tab [14] = '{8'h00, 8'h20, 8'h02, 8'h0a, 8'h12, 8'h04, 8'h0c,
                                   8'h14, 8'h06, 8'h0e, 8'h16, 8'h46, 8'h4e, 8'h56};
  logic [7:0]     st_tab [14] = '{8'h05, 8'h15, 8'h06, 8'h16, 8'h0f, 8'h8f, 8'h13,
                                  8'h93, 8'ha9, 8'haa, 8'hc9, 8'hca, 8'he9, 8'hea};
  always #2 mclk = ~mclk;
  typec_cc_register_bank i_typec_cc_register_bank (.mclk, .rst_n, .scl_in, .sda_in,
    .sda_out, .sda_oe, .attach_report, .interrupt_request_out_n, .sink_attached_out,
    .vbus_source_out, .port_cfg_out, .cc_pull_out);
  cc_i2c_host i_cc_i2c_host (.mclk(mclk), .sda_oe(sda_oe), .sda_out(sda_out),
    .scl(scl_in), .sda(sda_in));
  ////////////////////////////////////////////////////////////
  function automatic logic is_src(input logic [7:0] c);
    return c inside {8'h05, 8'h15, 8'h06, 8'h16};
  endfunction : is_src
  function automatic port_role_t exp_role(input logic [7:0] v);
    if (v[2:1] == 2'b01)
      return ROLE_SOURCE;
    return v[2] ? ROLE_DRP : ROLE_SINK;
  endfunction : exp_role
  function automatic cc_pull_t exp_pull(input logic [7:0] v);
    if (v[7:1] == 7'h00)
      return PULL_GND;
    return (v[2:1] == 2'b01) ? PULL_VDD : PULL_TOGGLE;
  endfunction : exp_pull
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // writes always pass through 01h; bytes past control must be ignored
  task automatic wr_ctl(input logic [7:0] v);
    logic [7:0] q;
    i_cc_i2c_host.start();
    i_cc_i2c_host.xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, q, ack);
    check("address ack", 8'h00, ack);
    i_cc_i2c_host.xfer(8'h00, 1'b1, q, ack);
    i_cc_i2c_host.xfer(v, 1'b1, q, ack);
    i_cc_i2c_host.xfer(8'hff, 1'b1, q, ack);
    i_cc_i2c_host.xfer(8'hff, 1'b1, q, ack);
    i_cc_i2c_host.stop();
  endtask : wr_ctl
  task automatic rd_all();
    logic [7:0] q;
    i_cc_i2c_host.start();
    i_cc_i2c_host.xfer({`I2C_DEV_ADDR, 1'b1}, 1'b1, q, ack);
    for (int i = 0; i < 5; i++)
      i_cc_i2c_host.xfer(8'hff, i == 4, rd[i], ack);
    i_cc_i2c_host.stop();
  endtask : rd_all
  task automatic report(input logic [7:0] c);
    @(negedge mclk);
    attach_report = {1'b1, c};
    @(negedge mclk);
    attach_report.valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : report
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] q;
    void'($urandom(32'h0000_c0cc));
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    check("irq", 8'h01, interrupt_request_out_n);
    check("cc pull", PULL_GND, cc_pull_out);
    rd_all();
    check("id", `ID_BYTE_VALUE, rd[0]);
    check("control", 8'h00, rd[1]);
    check("events", 8'h00, rd[2]);
    check("status", 8'h00, rd[3]);
    check("past end", 8'h00, rd[4]);
    i_cc_i2c_host.start();
    i_cc_i2c_host.xfer({`I2C_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
    check("foreign address", 8'h01, ack);
    i_cc_i2c_host.stop();
    foreach (ctl_tab[i]) begin
      v = ctl_tab[i] | 8'($urandom % 2);
      wr_ctl(v);
      repeat (4) @(negedge mclk);
      check("role", exp_role(v), port_cfg_out.role);
      check("cc pull", exp_pull(v), cc_pull_out);
      check("mask", v[0], port_cfg_out.irq_mask);
      check("try sink", v[6], port_cfg_out.try_snk);
      check("try source", v[2:1] == 2'b11 && !v[6], port_cfg_out.try_src);
      check("accessory", v[5], port_cfg_out.accessory);
      if (exp_role(v) != ROLE_SINK)
        check("advertised", v[4:3], port_cfg_out.adv);
      rd_all();
      check("control", v, rd[1]);
      check("events", 8'h00, rd[2]);
    end
    foreach (st_tab[i]) begin
      c = st_tab[i];
      v = 8'h46 | 8'($urandom % 2);
      wr_ctl(v);
      report(c);
      check("irq", v[0], interrupt_request_out_n);
      check("sink attached", !is_src(c), sink_attached_out);
      check("vbus", is_src(c), vbus_source_out);
      rd_all();
      check("events", 8'h01, rd[2]);
      check("status", c, rd[3]);
      @(negedge mclk);
      check("irq", 8'h01, interrupt_request_out_n);
      rd_all();
      check("events", 8'h00, rd[2]);
      check("status", c, rd[3]);
      report(8'h00);
      rd_all();
      check("events", 8'h02, rd[2]);
      check("status", 8'h00, rd[3]);
      check("vbus", 8'h00, vbus_source_out);
    end
    report(8'h05);
    report(8'h00);
    rd_all();
    check("events", 8'h03, rd[2]);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    check("cc pull", PULL_GND, cc_pull_out);
    rd_all();
    check("control", 8'h00, rd[1]);
    check("events", 8'h00, rd[2]);
    finish_test();
  end
endmodule : test_typec_cc_register_bank

bind typec_cc_register_bank typec_cc_props i_typec_cc_props (.mclk, .rst_n, .scl_in,
  .sda_in, .sda_out, .sda_oe, .attach_report, .interrupt_request_out_n,
  .sink_attached_out, .vbus_source_out, .port_cfg_out, .cc_pull_out);
